/* rtl/stpw_defs.vh */
// Register map, field positions and reset values of the triangle PWM block
// Functional notes
// - Symmetric triangle mode when both mode bits are 0; no changes while running.
// - Clearing count enable clears and stops the counter; counter cleared at reset.
// - Counter counts up and down; underflow event when reaching zero downward.
// - Cycle match event when counter equals cycle compare while counting up.
// - Up turns down at cycle match, down turns up at underflow.
// - Period is cycle buffer times two count clock periods.
// - Cycle buffer copied to cycle compare at underflow when transfer enabled.
// - Duty buffers copied to duty compares at underflow, gated by duty enable.
// - While stopped, a written duty buffer reaches its compare next clock.
// - Phase flip-flop sets on duty match while counting up.
// - Phase flip-flop resets on duty match while counting down.
// - One duty value governs set and reset within a period.
// - Each flip-flop change loads dead-time reload and starts countdown.
// - Dead-time counter counts to zero and halts instead of wrapping.
// - Dead time lasts reload plus one base clock periods.
// - Dead-time insertion on when disable bit is 0, bypassed when 1.
// - Positive phases on outputs 0,2,4, negatives on 1,3,5; never overlap.
// - Positive width is twice cycle minus both duties, less dead time.
// - Negative width is down duty plus next up duty, less dead time.
// - Zero or negative computed width keeps outputs inactive.
// - Outputs float after reset; after mode select positive inactive, negative active.
// - Active-level bit picks low or high active; default low active.
// - Duty above cycle keeps positive inactive and negative active.
// - Duty equal to cycle matches as counting down; flip-flop stays reset.
// - Software sets count enable last; then counting and six outputs run.
// - At cull ratio 1/1 underflow once per period; software reloads buffers.
`ifndef STPW_DEFS_VH
`define STPW_DEFS_VH
`define STPW_OFS_CTRL 4'h0
`define STPW_OFS_OUTMODE 4'h1
`define STPW_OFS_CYCBUF 4'h2
`define STPW_OFS_DUTYBUF_U 4'h3
`define STPW_OFS_DUTYBUF_V 4'h4
`define STPW_OFS_DUTYBUF_W 4'h5
`define STPW_OFS_DTRELOAD 4'h6
`define STPW_OFS_STATUS 4'h7
`define STPW_BIT_CE 15
`define STPW_BIT_DTDIS 14
`define STPW_BIT_CYCTE 13
`define STPW_BIT_DUTYTE 12
`define STPW_BIT_MODEHI 11
`define STPW_BIT_MODELO 10
`define STPW_BIT_CLKSEL 7
`define STPW_BIT_CULL 4
`define STPW_BIT_ALV 7
`define STPW_BIT_DIR 16
`define STPW_CTRL_RST 16'h0000
`define STPW_ALV_RST 1'b0
`define STPW_CLKSEL_MAX 3'h5
`define STPW_MODE_SYM 2'h0
`endif

/* rtl/stpw_prescale.v */
// Count clock prescaler: one-cycle tick every 2**sel base clocks, codes above 5 treated as 5
`timescale 1ns/100ps
`default_nettype none
`include "stpw_defs.vh"
module stpw_prescale (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Control
    input wire run_i,
    input wire [2:0] sel_i,
    // Tick
    output reg tick_o
);
    reg [4:0] div_reg;
    wire [2:0] sel_eff;
    wire [4:0] mask;

    // Codes above the last divider reuse the slowest one
    assign sel_eff = (sel_i > `STPW_CLKSEL_MAX) ? `STPW_CLKSEL_MAX : sel_i;
    assign mask = (5'h01 << sel_eff) - 5'h01;

    // Divider restarts with the counter so the first tick is aligned
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 5'h00;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            div_reg <= 5'h00;
            tick_o <= 1'b0;
        end else begin
            div_reg <= div_reg + 5'h01;
            tick_o <= ((div_reg & mask) == mask);
        end
    end
endmodule
`default_nettype wire

/* rtl/stpw_phase.v */
// One phase: output flip-flop with dead-time counter
`timescale 1ns/100ps
`default_nettype none
module stpw_phase #(
    parameter DT_W = 12
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Events from the compare logic
    input wire run_i,
    input wire set_i,
    input wire clr_i,
    // Dead-time control
    input wire dt_disable_i,
    input wire [DT_W-1:0] dt_reload_i,
    // Active levels before polarity
    output wire pos_act_o,
    output wire neg_act_o
);
    reg ff_reg;
    reg dt_run_reg;
    reg [DT_W-1:0] dt_cnt_reg;
    wire change;

    assign change = (set_i && !ff_reg) || (clr_i && ff_reg);

    // Stopped timer leaves the flip-flop reset: positive off, negative on
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ff_reg <= 1'b0;
            dt_run_reg <= 1'b0;
            dt_cnt_reg <= {DT_W{1'b0}};
        end else if (!run_i) begin
            ff_reg <= 1'b0;
            dt_run_reg <= 1'b0;
            dt_cnt_reg <= {DT_W{1'b0}};
        end else if (change) begin
            ff_reg <= set_i;
            dt_run_reg <= !dt_disable_i;
            dt_cnt_reg <= dt_reload_i;
        end else if (dt_run_reg) begin
            // Halts at zero rather than wrap; reload+1 blanked cycles
            if (dt_cnt_reg == {DT_W{1'b0}}) begin
                dt_run_reg <= 1'b0;
            end else begin
                dt_cnt_reg <= dt_cnt_reg - {{(DT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Both sides blanked while dead time runs, so they never overlap
    assign pos_act_o = ff_reg && !dt_run_reg;
    assign neg_act_o = !ff_reg && !dt_run_reg;
endmodule
`default_nettype wire

/* rtl/stpw_top.v */
// Symmetric triangle PWM generator with dead time, Avalon-MM slave
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "stpw_defs.vh"
module stpw_top #(
    parameter CNT_W = 16,
    parameter DT_W = 12
) (
    // Clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // Avalon-MM slave
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Event pulses
    output reg underflow_irq_o,
    output reg cycle_match_irq_o,
    // PWM pins: even index positive, odd index negative
    output reg [5:0] pwm_out_o,
    output reg [5:0] pwm_oe_o
);
    // Control and buffers
    reg [15:0] timer_control_reg;
    reg active_level_select_reg;
    reg mode_done_reg;
    reg [CNT_W-1:0] cycle_buffer_reg;
    reg [3*CNT_W-1:0] duty_buffer_reg;
    reg [DT_W-1:0] deadtime_reload_reg;
    // Timer state
    reg [CNT_W-1:0] cycle_compare_reg;
    reg [3*CNT_W-1:0] duty_compare_reg;
    reg [CNT_W-1:0] updown_counter_reg;
    reg down_reg;
    reg [2:0] cull_cnt_reg;
    reg [5:0] act_reg;

    wire count_enable_bit;
    wire deadtime_disable;
    wire cycle_transfer_enable;
    wire duty_transfer_enable;
    wire [1:0] mode_select;
    wire [2:0] count_clock_select;
    wire [2:0] interrupt_cull_ratio;
    wire run;
    wire tick;
    wire top_hit;
    wire bottom_hit;
    wire cull_hit;
    wire underflow_evt;
    wire bus_wr;
    wire [5:0] act_raw;
    wire [5:0] pin_next;

    assign count_enable_bit = timer_control_reg[`STPW_BIT_CE];
    assign deadtime_disable = timer_control_reg[`STPW_BIT_DTDIS];
    assign cycle_transfer_enable = timer_control_reg[`STPW_BIT_CYCTE];
    assign duty_transfer_enable = timer_control_reg[`STPW_BIT_DUTYTE];
    assign mode_select = {timer_control_reg[`STPW_BIT_MODEHI],
                          timer_control_reg[`STPW_BIT_MODELO]};
    assign count_clock_select = timer_control_reg[`STPW_BIT_CLKSEL+2:
                                                  `STPW_BIT_CLKSEL];
    assign interrupt_cull_ratio = timer_control_reg[`STPW_BIT_CULL+2:
                                                    `STPW_BIT_CULL];

    // Only the symmetric triangle mode runs; other codes keep it stopped
    assign run = count_enable_bit && (mode_select == `STPW_MODE_SYM);

    // Flip-flop set: match counting up; zero seen at the turn counts as up
    function match_set;
        input [CNT_W-1:0] cnt;
        input [CNT_W-1:0] duty;
        input [CNT_W-1:0] cyc;
        input down;
        begin
            match_set = (cnt == duty) &&
                        ((!down && (cnt != cyc)) ||
                         (down && (cnt == {CNT_W{1'b0}})));
        end
    endfunction

    // Flip-flop reset: match counting down; a match at the peak is down
    function match_clr;
        input [CNT_W-1:0] cnt;
        input [CNT_W-1:0] duty;
        input [CNT_W-1:0] cyc;
        input down;
        begin
            match_clr = (cnt == duty) &&
                        ((down && (cnt != {CNT_W{1'b0}})) ||
                         (!down && (cnt == cyc)));
        end
    endfunction

    stpw_prescale u_prescale (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .run_i(run),
        .sel_i(count_clock_select),
        .tick_o(tick)
    );

    // Turning points of the triangle, evaluated on count ticks only
    assign top_hit = tick && !down_reg &&
                     (updown_counter_reg == cycle_compare_reg);
    assign bottom_hit = tick && down_reg &&
                        (updown_counter_reg == {CNT_W{1'b0}});
    assign cull_hit = (cull_cnt_reg == interrupt_cull_ratio);
    // Culled underflow drives both the event pin and buffer transfers
    assign underflow_evt = bottom_hit && cull_hit;

    // Up/down counter; full period is two times cycle compare ticks
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            updown_counter_reg <= {CNT_W{1'b0}};
            down_reg <= 1'b0;
        end else if (!run) begin
            updown_counter_reg <= {CNT_W{1'b0}};
            down_reg <= 1'b0;
        end else if (tick) begin
            if (top_hit) begin
                down_reg <= 1'b1;
                updown_counter_reg <= updown_counter_reg -
                                      {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (bottom_hit) begin
                down_reg <= 1'b0;
                updown_counter_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (down_reg) begin
                updown_counter_reg <= updown_counter_reg -
                                      {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                updown_counter_reg <= updown_counter_reg +
                                      {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Underflow culling counter, restarted whenever counting stops
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cull_cnt_reg <= 3'h0;
        end else if (!run) begin
            cull_cnt_reg <= 3'h0;
        end else if (bottom_hit) begin
            cull_cnt_reg <= cull_hit ? 3'h0 : cull_cnt_reg + 3'h1;
        end
    end

    // Event pins are one-cycle pulses from flip-flops
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            underflow_irq_o <= 1'b0;
            cycle_match_irq_o <= 1'b0;
        end else begin
            underflow_irq_o <= underflow_evt;
            cycle_match_irq_o <= top_hit;
        end
    end

    // Compare registers: follow buffers while stopped, reload at underflow
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cycle_compare_reg <= {CNT_W{1'b0}};
            duty_compare_reg <= {(3*CNT_W){1'b0}};
        end else if (!count_enable_bit) begin
            cycle_compare_reg <= cycle_buffer_reg;
            duty_compare_reg <= duty_buffer_reg;
        end else if (underflow_evt) begin
            if (cycle_transfer_enable) begin
                cycle_compare_reg <= cycle_buffer_reg;
            end
            if (duty_transfer_enable) begin
                duty_compare_reg <= duty_buffer_reg;
            end
        end
    end

    // Per-phase matches feed the flip-flop and dead-time logic
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_phase
            wire [CNT_W-1:0] duty;
            wire ph_set;
            wire ph_clr;
            assign duty = duty_compare_reg[g*CNT_W +: CNT_W];
            // Duty above cycle never matches, so the phase stays reset
            assign ph_set = tick && match_set(updown_counter_reg, duty,
                cycle_compare_reg, down_reg);
            assign ph_clr = tick && match_clr(updown_counter_reg, duty,
                cycle_compare_reg, down_reg);
            stpw_phase #(
                .DT_W(DT_W)
            ) u_phase (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .run_i(run),
                .set_i(ph_set),
                .clr_i(ph_clr),
                .dt_disable_i(deadtime_disable),
                .dt_reload_i(deadtime_reload_reg),
                .pos_act_o(act_raw[2*g]),
                .neg_act_o(act_raw[2*g+1])
            );
        end
    endgenerate

    // Polarity: low active inverts both phases without touching timing
    assign pin_next = active_level_select_reg ? act_reg : ~act_reg;

    // Pins float until mode is chosen, then show pre-start levels
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_reg <= 6'h00;
            pwm_out_o <= 6'h00;
            pwm_oe_o <= 6'h00;
        end else begin
            act_reg <= act_raw;
            pwm_out_o <= pin_next;
            pwm_oe_o <= {6{mode_done_reg}};
        end
    end

    // Bus: a request is answered on the cycle after it is first seen
    assign bus_wr = avs_write_i && !avs_waitrequest_o;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Register writes land on the edge that completes the transfer
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_control_reg <= `STPW_CTRL_RST;
            active_level_select_reg <= `STPW_ALV_RST;
            mode_done_reg <= 1'b0;
            cycle_buffer_reg <= {CNT_W{1'b0}};
            duty_buffer_reg <= {(3*CNT_W){1'b0}};
            deadtime_reload_reg <= {DT_W{1'b0}};
        end else if (bus_wr) begin
            case (avs_address_i)
                `STPW_OFS_CTRL: begin
                    // Mode bits are frozen while the counter runs
                    if (count_enable_bit) begin
                        timer_control_reg <= {avs_writedata_i[15:12],
                            timer_control_reg[11:10],
                            avs_writedata_i[9:0]};
                    end else begin
                        timer_control_reg <= avs_writedata_i[15:0];
                        mode_done_reg <= (avs_writedata_i[11:10] ==
                                          `STPW_MODE_SYM);
                    end
                end
                `STPW_OFS_OUTMODE: begin
                    active_level_select_reg <=
                        avs_writedata_i[`STPW_BIT_ALV];
                end
                `STPW_OFS_CYCBUF: begin
                    cycle_buffer_reg <= avs_writedata_i[CNT_W-1:0];
                end
                `STPW_OFS_DUTYBUF_U: begin
                    duty_buffer_reg[CNT_W-1:0] <=
                        avs_writedata_i[CNT_W-1:0];
                end
                `STPW_OFS_DUTYBUF_V: begin
                    duty_buffer_reg[2*CNT_W-1:CNT_W] <=
                        avs_writedata_i[CNT_W-1:0];
                end
                `STPW_OFS_DUTYBUF_W: begin
                    duty_buffer_reg[3*CNT_W-1:2*CNT_W] <=
                        avs_writedata_i[CNT_W-1:0];
                end
                `STPW_OFS_DTRELOAD: begin
                    deadtime_reload_reg <= avs_writedata_i[DT_W-1:0];
                end
                default: begin
                    mode_done_reg <= mode_done_reg;
                end
            endcase
        end
    end

    // Read data registered with the answer; unmapped words read zero
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                `STPW_OFS_CTRL:
                    avs_readdata_o <= {16'h0000, timer_control_reg};
                `STPW_OFS_OUTMODE:
                    avs_readdata_o <= {24'h000000,
                                       active_level_select_reg, 7'h00};
                `STPW_OFS_CYCBUF:
                    avs_readdata_o <= {16'h0000, cycle_buffer_reg};
                `STPW_OFS_DUTYBUF_U:
                    avs_readdata_o <= {16'h0000,
                                       duty_buffer_reg[CNT_W-1:0]};
                `STPW_OFS_DUTYBUF_V:
                    avs_readdata_o <= {16'h0000,
                                       duty_buffer_reg[2*CNT_W-1:CNT_W]};
                `STPW_OFS_DUTYBUF_W:
                    avs_readdata_o <= {16'h0000,
                                       duty_buffer_reg[3*CNT_W-1:2*CNT_W]};
                `STPW_OFS_DTRELOAD:
                    avs_readdata_o <= {20'h00000, deadtime_reload_reg};
                `STPW_OFS_STATUS:
                    avs_readdata_o <= {15'h0000, down_reg,
                                       updown_counter_reg};
                default:
                    avs_readdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

/* testbench/stpw_top_chk.sv */
// Port-level checker for the triangle PWM block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
`include "stpw_defs.vh"
module stpw_top_chk #(
    parameter CNT_W = 16,
    parameter DT_W = 12
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register bus
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Events and pins
    input wire logic underflow_irq_o,
    input wire logic cycle_match_irq_o,
    input wire logic [5:0] pwm_out_o,
    input wire logic [5:0] pwm_oe_o
);
    logic [15:0] ctrl_reg;
    logic [DT_W-1:0] dt_reg;
    logic [7:0] gap_reg;
    logic [5:0] act;
    logic alv_reg, seen_reg, cm_reg, lpos_reg, wr_ok, ce;

    // Shadow of software settings; pins read as active levels
    assign wr_ok = avs_write_i && !avs_waitrequest_o;
    assign ce = ctrl_reg[`STPW_BIT_CE];
    assign act = alv_reg ? pwm_out_o : ~pwm_out_o;

    // Gap counter of pair u saturates, so long idle spans never wrap
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= 16'h0000;
            dt_reg <= '0;
            gap_reg <= 8'h00;
            {alv_reg, seen_reg, cm_reg, lpos_reg} <= 4'h0;
        end else begin
            if (wr_ok && avs_address_i == `STPW_OFS_CTRL) begin
                ctrl_reg <= avs_writedata_i[15:0];
                if (avs_writedata_i[11:10] == `STPW_MODE_SYM) seen_reg <= 1'b1;
            end
            if (wr_ok && avs_address_i == `STPW_OFS_OUTMODE)
                alv_reg <= avs_writedata_i[`STPW_BIT_ALV];
            if (wr_ok && avs_address_i == `STPW_OFS_DTRELOAD)
                dt_reg <= avs_writedata_i[DT_W-1:0];
            if (!ce) cm_reg <= 1'b0;
            else if (cycle_match_irq_o) cm_reg <= 1'b1;
            else if (underflow_irq_o) cm_reg <= 1'b0;
            if (act[0] | act[1]) gap_reg <= 8'h00;
            else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
            if (act[0] | act[1]) lpos_reg <= act[0];
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_float_reset: assert property (!seen_reg |-> pwm_oe_o == 6'h00)
        else $error("pins driven before mode select");
    a_stop_levels: assert property ((!ce && !$past(ce, 3) &&
        alv_reg == $past(alv_reg, 3) && pwm_oe_o == 6'h3f)
        |-> pwm_out_o == (alv_reg ? 6'h2a : 6'h15))
        else $error("wrong idle levels while stopped");
    a_no_overlap: assert property ((pwm_oe_o == 6'h3f &&
        alv_reg == $past(alv_reg, 3))
        |-> ((act[0] & act[1]) | (act[2] & act[3]) | (act[4] & act[5])) == 0)
        else $error("both phases of a pair active");
    a_dead_neg: assert property (($rose(act[1]) && ce && lpos_reg)
        |-> gap_reg == (ctrl_reg[`STPW_BIT_DTDIS] ? 0 : dt_reg + 1))
        else $error("wrong dead time before negative phase");
    a_dead_pos: assert property (($rose(act[0]) && ce && !lpos_reg)
        |-> gap_reg == (ctrl_reg[`STPW_BIT_DTDIS] ? 0 : dt_reg + 1))
        else $error("wrong dead time before positive phase");
    a_stop_quiet: assert property ((!ce && !$past(ce) && !$past(ce, 2))
        |-> !(underflow_irq_o || cycle_match_irq_o))
        else $error("event pulse while stopped");
    a_cm_order: assert property ((cycle_match_irq_o &&
        ctrl_reg[`STPW_BIT_CULL +: 3] == 3'h0) |-> !cm_reg)
        else $error("two cycle matches without underflow");
    a_uf_order: assert property ((underflow_irq_o &&
        ctrl_reg[`STPW_BIT_CULL +: 3] == 3'h0) |-> cm_reg)
        else $error("underflow without preceding cycle match");
    a_bus_answer: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered next cycle");
endmodule

bind stpw_top stpw_top_chk #(.CNT_W(CNT_W), .DT_W(DT_W)) stpw_top_chk_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .underflow_irq_o(underflow_irq_o),
    .cycle_match_irq_o(cycle_match_irq_o), .pwm_out_o(pwm_out_o),
    .pwm_oe_o(pwm_oe_o));
`default_nettype wire

/* testbench/tb_stpw_top.sv */
// Self-checking bench for the triangle PWM block
`timescale 1ns/100ps
`default_nettype none
`include "stpw_defs.vh"
module tb_stpw_top;
    logic clock_i, rst_n_i, avs_read_i, avs_write_i, alv;
    logic avs_waitrequest_o, underflow_irq_o, cycle_match_irq_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [5:0] pwm_out_o, pwm_oe_o, act;
    int num_errors, n_tests, seed, wlen, i, k, c, c2, cu;
    int pc[3], nc[3], cd[3], d2[3], de[3];

    stpw_top stpw_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .underflow_irq_o(underflow_irq_o), .cycle_match_irq_o(cycle_match_irq_o),
        .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Single exit point for normal end and for timeouts
    task give_verdict;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // One bus transfer; request held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 50) begin num_errors++; give_verdict; end
    endtask

    task wait_uf;
        int n;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (underflow_irq_o !== 1'b1 && n < 3000);
        if (n >= 3000) begin num_errors++; give_verdict; end
    endtask

    // Active cycles of each phase over one underflow-to-underflow window
    task measure;
        wlen = 0;
        pc = '{0, 0, 0};
        nc = '{0, 0, 0};
        do begin
            act = alv ? pwm_out_o : ~pwm_out_o;
            for (k = 0; k < 3; k++) begin
                pc[k] += act[2*k];
                nc[k] += act[2*k+1];
            end
            @(negedge clock_i);
            wlen++;
        end while (underflow_irq_o !== 1'b1 && wlen < 3000);
        if (wlen >= 3000) begin num_errors++; give_verdict; end
    endtask

    // Width less dead time, clipped to zero
    function int wid(input int a, input int td);
        return (a > td) ? a - td : 0;
    endfunction

    task expect_win(input int cy, input int d[3], input int t, input int td);
        // A culled window spans cu whole periods
        check(wlen, 2 * cy * t * cu);
        for (k = 0; k < 3; k++) begin
            if (d[k] >= cy) begin
                check(pc[k], 0);
                check(nc[k], 2 * cy * t * cu);
            end else begin
                check(pc[k], cu * wid(2 * (cy - d[k]) * t, td));
                check(nc[k], cu * wid(2 * d[k] * t, td));
            end
        end
    endtask

    // Configure while stopped, measure a window, reload buffers, measure again, stop
    task run(input int dt, input int sel, input int dis, input int te,
        input int cul);
        int ctl, t, td;
        t = 1 << sel;
        td = dis ? 0 : dt + 1;
        cu = cul + 1;
        ctl = (dis << 14) | (te << 12) | (sel << 7) | (cul << 4);
        bus(1'b1, `STPW_OFS_CTRL, ctl);
        bus(1'b1, `STPW_OFS_OUTMODE, {24'h0, alv, 7'h00});
        bus(1'b1, `STPW_OFS_CYCBUF, c);
        for (k = 0; k < 3; k++) bus(1'b1, 4'(`STPW_OFS_DUTYBUF_U + k), cd[k]);
        bus(1'b1, `STPW_OFS_DTRELOAD, dt);
        check(pwm_oe_o, 6'h3f);
        check(pwm_out_o, alv ? 6'h2a : 6'h15);
        bus(1'b1, `STPW_OFS_CTRL, ctl | 32'h8000);
        wait_uf;
        measure;
        expect_win(c, cd, t, td);
        bus(1'b1, `STPW_OFS_CYCBUF, c2);
        for (k = 0; k < 3; k++) bus(1'b1, 4'(`STPW_OFS_DUTYBUF_U + k), d2[k]);
        for (k = 0; k < 3; k++) de[k] = te[0] ? d2[k] : cd[k];
        wait_uf;
        measure;
        expect_win(te[1] ? c2 : c, de, t, td);
        bus(1'b1, `STPW_OFS_CTRL, ctl);
        bus(1'b0, `STPW_OFS_STATUS, 32'h0);
        check(q[15:0], 16'h0000);
    endtask

    initial begin
        seed = 43;
        num_errors = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        {avs_read_i, avs_write_i, alv} = 3'h0;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        check(pwm_oe_o, 6'h00);
        bus(1'b0, `STPW_OFS_CTRL, 32'h0);
        check(q, 32'h0);
        bus(1'b0, `STPW_OFS_OUTMODE, 32'h0);
        check(q, 32'h0);
        // Unmapped place: write ignored, read gives zero, pins stay off
        bus(1'b1, 4'h9, $random(seed));
        bus(1'b0, 4'h9, 32'h0);
        check(q, 32'h0);
        check(pwm_oe_o, 6'h00);
        // Duty equal to cycle; duty above cycle only loaded while running
        alv = 1'b1;
        c = 20;
        c2 = 20;
        cd = '{20, 19, 10};
        d2 = '{20, 21, 10};
        run(2, 0, 0, 3, 0);
        alv = 1'b0;
        cd = '{15, 5, 4};
        d2 = cd;
        run(30, 0, 0, 3, 0);
        // Random settings, reloads and transfer gating
        for (i = 0; i < 6; i++) begin
            c = 12 + ($random(seed) & 15);
            c2 = 12 + ($random(seed) & 15);
            for (k = 0; k < 3; k++) begin
                cd[k] = 6 + ($random(seed) & 31) % (c - 11);
                d2[k] = 6 + ($random(seed) & 31) % (c2 - 11);
            end
            alv = 1'($random(seed));
            run($random(seed) & 3, ($random(seed) & 3) % 3, $random(seed) & 1,
                $random(seed) & 3, $random(seed) & 7);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
